/* File: rtl/cdq_core.v */
// dictionary key checker and event queue
`timescale 1ns/10ps
`include "cdq_map.vh"
module cdq_core (
  input wire ref_clk_i,
  input wire rst_n_i,
  // key request
  input wire req_valid_i,
  input wire req_write_i,
  input wire [127:0] key_i,
  input wire [4:0] key_len_i,
  input wire [7:0] val_len_i,
  input wire [7:0] val_i,
  input wire sig_ok_i,
  // key lookup request and answer, dictionary store write and key response
  output wire lookup_req_o,
  input wire lookup_hit_i,
  input wire [1:0] lookup_acc_i,
  input wire [7:0] lookup_buf_i,
  input wire lookup_cert_i,
  input wire lookup_persist_i,
  input wire [7:0] lookup_val_i,
  output reg store_we_o,
  output reg [7:0] store_val_o,
  output reg resp_valid_o,
  output reg [4:0] resp_err_o,
  output reg resp_has_val_o,
  output reg [7:0] resp_val_o,
  // events
  input wire ev_valid_i,
  input wire [15:0] ev_id_i,
  input wire [15:0] ev_param_i,
  input wire fetch_i,
  input wire clear_i,
  output reg fetch_valid_o,
  output reg fetch_has_ev_o,
  output reg [15:0] fetch_id_o,
  output reg [15:0] fetch_param_o,
  output wire event_pending_o,
  output wire [3:0] ev_count_o,
  output wire np_reinit_o
);
  // ***********************************
  // key checks
  // ***********************************
  wire [15:0] bad_ch;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_ch
      cdq_char_chk u_chk (
        .ch_i(key_i[gi*8 +: 8]),
        .used_i(gi < key_len_i),
        .bad_o(bad_ch[gi])
      );
    end
  endgenerate
  wire len_bad;
  wire name_bad;
  assign len_bad = (key_len_i == 5'd0) || (key_len_i > `CDQ_KEY_MAX);
  assign name_bad = |bad_ch;
  assign lookup_req_o = req_valid_i && !len_bad && !name_bad;
  reg [4:0] err_d;
  always @* begin
    err_d = `CDQ_ERR_NONE;
    if (len_bad) begin
      err_d = `CDQ_ERR_KEYLEN;
    end else if (name_bad) begin
      err_d = `CDQ_ERR_KEYNAME;
    end else if (!lookup_hit_i) begin
      err_d = `CDQ_ERR_UNKNOWN;
    end else if (req_write_i && lookup_acc_i == `CDQ_ACC_RO) begin
      err_d = `CDQ_ERR_RDONLY;
    end else if (!req_write_i && lookup_acc_i == `CDQ_ACC_WO) begin
      err_d = `CDQ_ERR_WRONLY;
    end else if (req_write_i && val_len_i > lookup_buf_i) begin
      err_d = `CDQ_ERR_PARAM;
    end else if (req_write_i && lookup_cert_i && !sig_ok_i) begin
      err_d = `CDQ_ERR_SIG;
    end
  end
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      resp_valid_o <= 1'b0;
      resp_err_o <= `CDQ_ERR_NONE;
      resp_has_val_o <= 1'b0;
      resp_val_o <= 8'h00;
      store_we_o <= 1'b0;
      store_val_o <= 8'h00;
    end else begin
      resp_valid_o <= req_valid_i;
      store_we_o <= 1'b0;
      resp_has_val_o <= 1'b0;
      if (req_valid_i) begin
        resp_err_o <= err_d;
        if (err_d == `CDQ_ERR_NONE && req_write_i) begin
          store_we_o <= 1'b1;
          store_val_o <= val_i;
        end
        if (err_d == `CDQ_ERR_NONE && !req_write_i) begin
          resp_has_val_o <= 1'b1;
          resp_val_o <= lookup_val_i;
        end else begin
          resp_val_o <= 8'h00;
        end
      end
    end
  end
  // non-persistent keys reload while reset or a reset command is seen
  assign np_reinit_o = !rst_n_i || clear_i;
  // ***********************************
  // event queue
  // ***********************************
  reg [15:0] q_id [0:`CDQ_EV_DEPTH-1];
  reg [15:0] q_par [0:`CDQ_EV_DEPTH-1];
  reg [`CDQ_EV_AW-1:0] rd_q;
  reg [`CDQ_EV_AW-1:0] wr_q;
  reg [3:0] cnt_q;
  wire id_ok;
  assign id_ok = (ev_id_i >= `CDQ_EV_CORE_LO && ev_id_i <= `CDQ_EV_CORE_HI)
    || (ev_id_i >= `CDQ_EV_SHD_LO && ev_id_i <= `CDQ_EV_SHD_HI)
    || (ev_id_i >= `CDQ_EV_BLE_LO && ev_id_i <= `CDQ_EV_BLE_HI)
    || (ev_id_i >= `CDQ_EV_CUSTOM);
  wire push;
  wire full;
  wire pop;
  assign push = ev_valid_i && id_ok && !clear_i;
  assign full = (cnt_q == `CDQ_EV_DEPTH);
  assign pop = fetch_i && (cnt_q != 4'd0) && !clear_i;
  assign event_pending_o = (cnt_q != 4'd0);
  assign ev_count_o = cnt_q;
  always @(posedge ref_clk_i) begin
    if (push) begin
      q_id[wr_q] <= ev_id_i;
      q_par[wr_q] <= ev_param_i;
    end
  end
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rd_q <= {`CDQ_EV_AW{1'b0}};
      wr_q <= {`CDQ_EV_AW{1'b0}};
      cnt_q <= 4'd0;
      fetch_valid_o <= 1'b0;
      fetch_has_ev_o <= 1'b0;
      fetch_id_o <= 16'h0000;
      fetch_param_o <= 16'h0000;
    end else begin
      fetch_valid_o <= fetch_i;
      fetch_has_ev_o <= pop;
      if (pop) begin
        fetch_id_o <= q_id[rd_q];
        fetch_param_o <= q_par[rd_q];
      end else begin
        fetch_id_o <= 16'h0000;
        fetch_param_o <= 16'h0000;
      end
      if (clear_i) begin
        rd_q <= {`CDQ_EV_AW{1'b0}};
        wr_q <= {`CDQ_EV_AW{1'b0}};
        cnt_q <= 4'd0;
      end else begin
        if (push) begin
          wr_q <= wr_q + 1'b1;
        end
        if ((push && full) || pop) begin
          rd_q <= rd_q + 1'b1;
        end
        if (push && !pop && !full) begin
          cnt_q <= cnt_q + 4'd1;
        end else if (pop && !push) begin
          cnt_q <= cnt_q - 4'd1;
        end
      end
    end
  end
endmodule

/* File: rtl/cdq_map.vh */
// constants for the dictionary checker and event queue
`ifndef CDQ_MAP_VH
`define CDQ_MAP_VH
// ***********************************
// key and response codes
// ***********************************
`define CDQ_KEY_MAX 5'd16
`define CDQ_ERR_NONE 5'd0
`define CDQ_ERR_PARAM 5'd4
`define CDQ_ERR_KEYLEN 5'd9
`define CDQ_ERR_KEYNAME 5'd10
`define CDQ_ERR_UNKNOWN 5'd11
`define CDQ_ERR_RDONLY 5'd12
`define CDQ_ERR_WRONLY 5'd13
`define CDQ_ERR_SIG 5'd23
// ***********************************
// key access kinds
// ***********************************
`define CDQ_ACC_RW 2'd0
`define CDQ_ACC_RO 2'd1
`define CDQ_ACC_WO 2'd2
// ***********************************
// event identifier ranges and queue depth
// ***********************************
`define CDQ_EV_CORE_LO 16'd1
`define CDQ_EV_CORE_HI 16'd10
`define CDQ_EV_SHD_LO 16'd20
`define CDQ_EV_SHD_HI 16'd27
`define CDQ_EV_BLE_LO 16'd40
`define CDQ_EV_BLE_HI 16'd47
`define CDQ_EV_CUSTOM 16'd1000
`define CDQ_EV_DEPTH 8
`define CDQ_EV_AW 3
`endif

/* File: rtl/cdq_char_chk.v */
// one key character classifier
`timescale 1ns/10ps
module cdq_char_chk (
  input wire [7:0] ch_i,
  input wire used_i,
  output wire bad_o
);
  wire is_dig;
  wire is_up;
  wire is_lo;
  assign is_dig = (ch_i >= 8'h30) && (ch_i <= 8'h39);
  assign is_up = (ch_i >= 8'h41) && (ch_i <= 8'h5a);
  assign is_lo = (ch_i >= 8'h61) && (ch_i <= 8'h7a);
  assign bad_o = used_i && !(is_dig || is_up || is_lo);
endmodule

/* File: sim/cdq_core_assertions.sv */
// port checker for the key checker and event queue
`timescale 1ns/10ps
module cdq_core_assertions (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire req_valid_i,
  input wire [4:0] key_len_i,
  input wire fetch_i,
  input wire clear_i,
  input wire ev_valid_i,
  input wire [15:0] ev_id_i,
  input wire lookup_req_o,
  input wire resp_valid_o,
  input wire [4:0] resp_err_o,
  input wire fetch_valid_o,
  input wire event_pending_o,
  input wire [3:0] ev_count_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_resp_one_cycle: assert property (req_valid_i |=> resp_valid_o) else $error("no response");
  a_keylen_err: assert property (req_valid_i && key_len_i > 5'd16 |=> resp_err_o == 5'd9)
    else $error("long key not error 9");
  a_long_no_lookup: assert property (req_valid_i && key_len_i > 5'd16 |-> !lookup_req_o)
    else $error("long key looked up");
  a_pend_level: assert property (event_pending_o == (ev_count_o != 4'd0)) else $error("pending");
  a_clear_empty: assert property (clear_i |=> ev_count_o == 4'd0) else $error("clear kept events");
  a_fetch_answer: assert property (fetch_i |=> fetch_valid_o) else $error("no fetch answer");
  a_reserved_drop: assert property (ev_valid_i && ev_id_i inside {[11:19], [28:39]} && !fetch_i
    && !clear_i |=> $stable(ev_count_o)) else $error("reserved id queued");
  a_push_count: assert property (ev_valid_i && ev_id_i >= 16'd1000 && ev_count_o < 4'd8 && !fetch_i
    && !clear_i |=> ev_count_o == $past(ev_count_o) + 4'd1) else $error("push not counted");
  a_full_wrap: assert property (ev_valid_i && ev_id_i >= 16'd1000 && ev_count_o == 4'd8 && !fetch_i
    && !clear_i |=> ev_count_o == 4'd8) else $error("full push changed count");
endmodule
bind cdq_core cdq_core_assertions chk_u (.*);

/* File: sim/cdq_dict_model.sv */
// dictionary store model answering key lookups
`timescale 1ns/10ps
module cdq_dict_model (
  input wire ref_clk_i,
  input wire [7:0] key_ch_i,
  input wire store_we_i,
  input wire [7:0] store_val_i,
  input wire np_reinit_i,
  output reg hit_o,
  output reg [1:0] acc_o,
  output reg cert_o,
  output reg [7:0] val_o
);
  reg [7:0] val_q = 8'h00;
  always @(posedge ref_clk_i) begin
    if (np_reinit_i) val_q <= 8'h00;
    else if (store_we_i) val_q <= store_val_i;
  end
  always @* begin
    hit_o = 1'b1;
    acc_o = 2'd0;
    cert_o = 1'b0;
    val_o = val_q;
    case (key_ch_i)
      8'h41: hit_o = 1'b1;
      8'h42: acc_o = 2'd1;
      8'h43: acc_o = 2'd2;
      8'h44: cert_o = 1'b1;
      default: hit_o = 1'b0;
    endcase
  end
endmodule

/* File: sim/config_dictionary_and_event_queue_test.sv */
// bench for the key checker and event queue
`timescale 1ns/10ps
module config_dictionary_and_event_queue_test;
  logic ref_clk_i = 0, rst_n_i = 0, req_valid_i = 0, req_write_i = 0, sig_ok_i = 1, ev_valid_i = 0;
  logic fetch_i = 0, clear_i = 0, lookup_hit_i, lookup_cert_i, lookup_persist_i = 0;
  logic [127:0] key_i = 0;
  logic [4:0] key_len_i = 0, resp_err_o;
  logic [7:0] val_len_i = 0, val_i = 8'h5a, lookup_buf_i = 8'h04, lookup_val_i, store_val_o, resp_val_o;
  logic [15:0] ev_id_i = 0, ev_param_i = 0, fetch_id_o, fetch_param_o;
  logic [1:0] lookup_acc_i;
  logic [3:0] ev_count_o;
  logic lookup_req_o, store_we_o, resp_valid_o, resp_has_val_o, fetch_valid_o, fetch_has_ev_o;
  logic event_pending_o, np_reinit_o;
  integer n_mismatch = 0, checks = 0, i;
  always #25 ref_clk_i = ~ref_clk_i;
  cdq_core dut_u (.*);
  cdq_dict_model dict_u (.ref_clk_i(ref_clk_i), .key_ch_i(key_i[7:0]), .store_we_i(store_we_o),
    .store_val_i(store_val_o), .np_reinit_i(np_reinit_o), .hit_o(lookup_hit_i),
    .acc_o(lookup_acc_i), .cert_o(lookup_cert_i), .val_o(lookup_val_i));
  task chk(input string nm, input [15:0] e, input [15:0] g);
    checks = checks + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task kreq(input w, input [7:0] c, input [4:0] n, input [7:0] vl, input s, input [4:0] e);
    {req_valid_i, req_write_i, key_i, key_len_i, val_len_i, sig_ok_i} = {1'b1, w, {16{c}}, n, vl, s};
    @(negedge ref_clk_i) req_valid_i = 0;
    chk("resp_valid", 1, resp_valid_o);
    chk("resp_err", e, resp_err_o);
  endtask
  task ev(input [15:0] id);
    {ev_valid_i, ev_id_i, ev_param_i} = {1'b1, id, ~id};
    @(negedge ref_clk_i) ev_valid_i = 0;
  endtask
  task fe(input h, input [15:0] id);
    fetch_i = 1;
    @(negedge ref_clk_i) fetch_i = 0;
    chk("fetch_valid", 1, fetch_valid_o);
    chk("fetch_has", h, fetch_has_ev_o);
    chk("fetch_id", id, fetch_id_o);
    chk("fetch_param", h ? ~id : 16'h0000, fetch_param_o);
  endtask
  task t_keys;
    kreq(1, 8'h41, 5'd17, 0, 1, 5'd9);
    kreq(1, 8'h2d, 5'd17, 0, 1, 5'd9);
    kreq(0, 8'h2d, 5'd3, 0, 1, 5'd10);
    kreq(0, 8'h5a, 5'd16, 0, 1, 5'd11);
    kreq(0, 8'h61, 5'd1, 0, 1, 5'd11);
    kreq(1, 8'h42, 5'd2, 0, 1, 5'd12);
    kreq(1, 8'h41, 5'd4, 8'h05, 1, 5'd4);
    kreq(1, 8'h44, 5'd4, 0, 0, 5'd23);
    kreq(1, 8'h41, 5'd16, 0, 1, 5'd0);
    kreq(0, 8'h43, 5'd1, 0, 1, 5'd13);
    chk("has_val", 0, resp_has_val_o);
    kreq(0, 8'h41, 5'd1, 0, 1, 5'd0);
    chk("resp_val", 8'h5a, resp_val_o);
  endtask
  task t_queue;
    fe(0, 0);
    ev(2); ev(21); ev(15); ev(47); ev(500); ev(1000);
    chk("count", 4, ev_count_o);
    fe(1, 2); fe(1, 21); fe(1, 47); fe(1, 1000);
    for (i = 0; i < 10; i++) ev(1000 + i);
    chk("count", 8, ev_count_o);
    fe(1, 1002);
    kreq(0, 8'h41, 5'd1, 0, 1, 5'd0);
    chk("count", 7, ev_count_o);
    clear_i = 1;
    @(negedge ref_clk_i) clear_i = 0;
    chk("pending", 0, event_pending_o);
    rst_n_i = 0;
    @(negedge ref_clk_i) rst_n_i = 1;
    kreq(0, 8'h41, 5'd1, 0, 1, 5'd0);
    chk("resp_val", 0, resp_val_o);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge ref_clk_i);
    rst_n_i = 1;
    t_keys;
    t_queue;
    test_done;
  end
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    test_done;
  end
endmodule
